/* core/pmc_pkg.sv */
// How it works
// - Output latch eight bits, read/write, resets zero
// - Output pin reads back latched value
// - Input pin reads back live pin level
// - Direction bit one drives, zero receives
// - Latch and direction drive pins only in plain mode
// - Direction register write-only, reads all ones
// - Mode register resets C0, top bits fixed
// - Mode bit five: serial out two drain
// - Mode bit two: serial out one drain
// - Mode bit four: capture noise filter on
// - Mode bit three: port4 pin3 as interrupt0
// - Mode bit one: pin1 as up/down input
// - Mode bit zero: pin0 interrupt4/trigger input
// - Drain select bit n: pin n open drain
package pmc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] PMC_ADDR_MODE = 16'hFFC9;
  localparam logic [15:0] PMC_ADDR_DRAIN = 16'hFFCB;
  localparam logic [15:0] PMC_ADDR_DATA = 16'hFFD5;
  localparam logic [15:0] PMC_ADDR_DIR = 16'hFFE5;
  // ----------------------------------------
  // Reset values, fixed bits and direction read value
  // ----------------------------------------
  localparam logic [7:0] PMC_RST_MODE = 8'hC0;
  localparam logic [7:0] PMC_RST_ZERO = 8'h00;
  localparam logic [7:0] PMC_MODE_FIXED = 8'hC0;
  localparam logic [7:0] PMC_ALL_ONES = 8'hFF;
  // ----------------------------------------
  // Mode register field positions
  // ----------------------------------------
  localparam int PMC_BIT_INT4_SEL = 0;
  localparam int PMC_BIT_UPDN_SEL = 1;
  localparam int PMC_BIT_OUT1_DRAIN = 2;
  localparam int PMC_BIT_INT0_SEL = 3;
  localparam int PMC_BIT_FILTER_EN = 4;
  localparam int PMC_BIT_OUT2_DRAIN = 5;
  // ----------------------------------------
  // Pin positions and count
  // ----------------------------------------
  localparam int PMC_PIN_INT4 = 0;
  localparam int PMC_PIN_UPDN = 1;
  localparam int PMC_PIN_COUNT = 8;
endpackage

/* core/pmc_port2.sv */
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
module pmc_port2
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Port pins, three signals each
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  // Alternate functions to peripherals
  output logic up_down_input,
  output logic ext_interrupt4_input,
  output logic converter_external_trigger,
  output logic ext_interrupt0_pin_select,
  output logic up_down_control_select,
  output logic ext_interrupt4_pin_select,
  output logic capture_noise_filter_enable,
  output logic serial_out1_drain_mode,
  output logic serial_out2_drain_mode
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] port2_output_data_reg;
  logic [7:0] port2_direction_reg;
  logic [7:0] port2_pin_function_mode_reg;
  logic [7:0] port2_open_drain_select_reg;
  logic [7:0] pin_meta_reg;
  logic [7:0] pin_sync_reg;
  logic [7:0] rdata_next;

  // Address decode
  wire sel_data = reg_addr == PMC_ADDR_DATA;
  wire sel_dir = reg_addr == PMC_ADDR_DIR;
  wire sel_mode = reg_addr == PMC_ADDR_MODE;
  wire sel_drain = reg_addr == PMC_ADDR_DRAIN;

  // Pins 0 and 1 leave plain mode when claimed by an alternate
  wire [7:0] alt_claim = {6'h00, port2_pin_function_mode_reg[PMC_BIT_UPDN_SEL],
    port2_pin_function_mode_reg[PMC_BIT_INT4_SEL]};
  wire [7:0] gp_drive = port2_direction_reg & ~alt_claim;

  // Pin synchroniser; first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    pin_meta_reg <= pin_in;
    pin_sync_reg <= pin_meta_reg;
  end

  // Register writes
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      port2_output_data_reg <= PMC_RST_ZERO;
      port2_direction_reg <= PMC_RST_ZERO;
      port2_pin_function_mode_reg <= PMC_RST_MODE;
      port2_open_drain_select_reg <= PMC_RST_ZERO;
    end else if (reg_wr) begin
      if (sel_data) port2_output_data_reg <= reg_wdata;
      if (sel_dir) port2_direction_reg <= reg_wdata;
      if (sel_mode) port2_pin_function_mode_reg <= reg_wdata | PMC_MODE_FIXED;
      if (sel_drain) port2_open_drain_select_reg <= reg_wdata;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = PMC_RST_ZERO;
    if (sel_data)
      rdata_next = (port2_direction_reg & port2_output_data_reg)
        | (~port2_direction_reg & pin_sync_reg);
    else if (sel_dir)
      rdata_next = PMC_ALL_ONES;
    else if (sel_mode)
      rdata_next = port2_pin_function_mode_reg | PMC_MODE_FIXED;
    else if (sel_drain)
      rdata_next = port2_open_drain_select_reg;
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!nrst) reg_rdata <= PMC_RST_ZERO;
    else if (reg_rd) reg_rdata <= rdata_next;
    else reg_rdata <= PMC_RST_ZERO;
  end

  // Drivers: open drain only pulls low, so enable follows a zero
  assign pin_out = port2_output_data_reg;
  assign pin_oe = gp_drive & (~port2_open_drain_select_reg
    | ~port2_output_data_reg);

  // Mode outputs; interrupt enable handling is software's job
  assign up_down_control_select = port2_pin_function_mode_reg[PMC_BIT_UPDN_SEL];
  assign ext_interrupt4_pin_select = port2_pin_function_mode_reg[PMC_BIT_INT4_SEL];
  assign ext_interrupt0_pin_select = port2_pin_function_mode_reg[PMC_BIT_INT0_SEL];
  assign capture_noise_filter_enable = port2_pin_function_mode_reg[PMC_BIT_FILTER_EN];
  assign serial_out1_drain_mode = port2_pin_function_mode_reg[PMC_BIT_OUT1_DRAIN];
  assign serial_out2_drain_mode = port2_pin_function_mode_reg[PMC_BIT_OUT2_DRAIN];
  // Alternate inputs idle high when not selected (active-low sources)
  assign up_down_input = up_down_control_select ? pin_sync_reg[PMC_PIN_UPDN] : 1'b1;
  assign ext_interrupt4_input = ext_interrupt4_pin_select ? pin_sync_reg[PMC_PIN_INT4]
    : 1'b1;
  assign converter_external_trigger = ext_interrupt4_input;

  // ----------------------------------------
  // Checks: reset
  // ----------------------------------------
  // Reset is the antecedent here, so these carry no disable
  a_reset_values: assert property (@(posedge sys_clk)
    !nrst |=> port2_output_data_reg == PMC_RST_ZERO
      && port2_direction_reg == PMC_RST_ZERO
      && port2_pin_function_mode_reg == PMC_RST_MODE
      && port2_open_drain_select_reg == PMC_RST_ZERO)
    else $error("register not at reset value");

  // A read cut off by reset must not leak out afterwards
  a_reset_rdata: assert property (@(posedge sys_clk)
    !nrst |=> reg_rdata == PMC_RST_ZERO)
    else $error("read data not cleared by reset");

  // Drivers are off while reset is held, so pins float
  a_reset_no_drive: assert property (@(posedge sys_clk)
    !nrst |=> pin_oe == PMC_RST_ZERO)
    else $error("pin driven after reset");

  // ----------------------------------------
  // Checks: register writes
  // ----------------------------------------
  // Latch takes the written byte at the strobe edge
  a_data_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && sel_data |=> port2_output_data_reg == $past(reg_wdata))
    else $error("data latch not written");

  // Latch holds without a write to it; a stray decode would show here
  a_data_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(reg_wr && sel_data) |=> port2_output_data_reg == $past(port2_output_data_reg))
    else $error("data latch changed without write");

  // Direction register takes the written byte
  a_dir_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && sel_dir |=> port2_direction_reg == $past(reg_wdata))
    else $error("direction not written");

  // Direction holds without a write to it
  a_dir_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(reg_wr && sel_dir) |=> port2_direction_reg == $past(port2_direction_reg))
    else $error("direction changed without write");

  // Mode write keeps the reserved top bits set
  a_mode_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && sel_mode |=>
      port2_pin_function_mode_reg == ($past(reg_wdata) | PMC_MODE_FIXED))
    else $error("mode not written");

  // Reserved mode bits never clear, whatever was written
  a_mode_top_bits: assert property (@(posedge sys_clk) disable iff (!nrst)
    (port2_pin_function_mode_reg & PMC_MODE_FIXED) == PMC_MODE_FIXED)
    else $error("mode top bits not set");

  // Drain select takes the written byte
  a_drain_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && sel_drain |=> port2_open_drain_select_reg == $past(reg_wdata))
    else $error("drain select not written");

  // Drain select holds without a write to it
  a_drain_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(reg_wr && sel_drain) |=>
      port2_open_drain_select_reg == $past(port2_open_drain_select_reg))
    else $error("drain select changed without write");

  // ----------------------------------------
  // Checks: register reads
  // ----------------------------------------
  // Direction is write-only: software cannot learn it back
  a_dir_reads_ones: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd && sel_dir |=> reg_rdata == PMC_ALL_ONES)
    else $error("direction read not all ones");

  // Mode reads show the stored bits plus the fixed top pair
  a_mode_reads: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd && sel_mode |=> reg_rdata == ($past(port2_pin_function_mode_reg) | PMC_MODE_FIXED))
    else $error("mode read wrong");

  // Drain select reads back what was stored
  a_drain_reads: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd && sel_drain |=> reg_rdata == $past(port2_open_drain_select_reg))
    else $error("drain select read wrong");

  // Output pins read back the latch, not the wire
  a_out_readback: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd && sel_data && port2_direction_reg[3] |=>
      reg_rdata[3] == $past(port2_output_data_reg[3]))
    else $error("output readback wrong");

  // Input pins read back the synchronised wire
  a_in_readback: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd && sel_data && !port2_direction_reg[4] |=>
      reg_rdata[4] == $past(pin_sync_reg[4]))
    else $error("input readback wrong");

  // Pin levels reach logic two flops after the pin, never sooner
  a_sync_depth: assert property (@(posedge sys_clk) disable iff (!nrst)
    pin_sync_reg == $past(pin_in, 2))
    else $error("pin synchroniser depth wrong");

  // ----------------------------------------
  // Checks: mode outputs
  // ----------------------------------------
  // Each mode output follows the bit last written to it
  a_out2_drain_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && sel_mode |=> serial_out2_drain_mode == $past(reg_wdata[PMC_BIT_OUT2_DRAIN]))
    else $error("serial out two drain mode wrong");

  a_filter_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && sel_mode |=> capture_noise_filter_enable == $past(reg_wdata[PMC_BIT_FILTER_EN]))
    else $error("capture filter enable wrong");

  a_int0_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && sel_mode |=> ext_interrupt0_pin_select == $past(reg_wdata[PMC_BIT_INT0_SEL]))
    else $error("interrupt0 select wrong");

  a_out1_drain_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && sel_mode |=> serial_out1_drain_mode == $past(reg_wdata[PMC_BIT_OUT1_DRAIN]))
    else $error("serial out one drain mode wrong");

  a_updn_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && sel_mode |=> up_down_control_select == $past(reg_wdata[PMC_BIT_UPDN_SEL]))
    else $error("up down select wrong");

  a_int4_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && sel_mode |=> ext_interrupt4_pin_select == $past(reg_wdata[PMC_BIT_INT4_SEL]))
    else $error("interrupt4 select wrong");

  // ----------------------------------------
  // Checks: alternate inputs
  // ----------------------------------------
  // Unselected alternate inputs idle high so no false event fires
  a_updn_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
    !up_down_control_select |-> up_down_input)
    else $error("up down input not idle");

  // Selected, the count direction follows pin 1
  a_updn_follows: assert property (@(posedge sys_clk) disable iff (!nrst)
    up_down_control_select |-> up_down_input == pin_sync_reg[PMC_PIN_UPDN])
    else $error("up down input not following pin");

  // Interrupt 4 input idles high while pin 0 is plain
  a_int4_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
    !ext_interrupt4_pin_select |-> ext_interrupt4_input)
    else $error("interrupt4 input not idle");

  // Selected, interrupt 4 follows pin 0
  a_int4_follows: assert property (@(posedge sys_clk) disable iff (!nrst)
    ext_interrupt4_pin_select |-> ext_interrupt4_input == pin_sync_reg[PMC_PIN_INT4])
    else $error("interrupt4 input not following pin");

  // Trigger shares pin 0 with interrupt 4 and sees the same level
  a_trig_follows: assert property (@(posedge sys_clk) disable iff (!nrst)
    ext_interrupt4_pin_select |-> converter_external_trigger == pin_sync_reg[PMC_PIN_INT4])
    else $error("trigger input not following pin");

  // ----------------------------------------
  // Checks: pin drivers
  // ----------------------------------------
  // Claimed pins never drive, whatever direction says
  a_alt_no_drive: assert property (@(posedge sys_clk) disable iff (!nrst)
    up_down_control_select |-> !pin_oe[PMC_PIN_UPDN])
    else $error("pin1 driven in alternate mode");

  a_alt0_no_drive: assert property (@(posedge sys_clk) disable iff (!nrst)
    ext_interrupt4_pin_select |-> !pin_oe[PMC_PIN_INT4])
    else $error("pin0 driven in alternate mode");

  // Per-pin driver rules, one copy per port pin
  for (genvar i = 0; i < PMC_PIN_COUNT; i++) begin : g_pin
    // An input pin is never driven
    a_input_no_drive: assert property (@(posedge sys_clk) disable iff (!nrst)
      !port2_direction_reg[i] |-> !pin_oe[i])
      else $error("input pin driven");

    // Open drain releases a high latch bit to the board
    a_od_high_off: assert property (@(posedge sys_clk) disable iff (!nrst)
      port2_open_drain_select_reg[i] && port2_output_data_reg[i] |-> !pin_oe[i])
      else $error("open drain drives high");

    // Open drain still pulls a low latch bit down
    a_od_low_on: assert property (@(posedge sys_clk) disable iff (!nrst)
      gp_drive[i] && port2_open_drain_select_reg[i] && !port2_output_data_reg[i]
        |-> pin_oe[i])
      else $error("open drain not pulling low");

    // Push-pull drives both levels
    a_cmos_drives: assert property (@(posedge sys_clk) disable iff (!nrst)
      gp_drive[i] && !port2_open_drain_select_reg[i] |-> pin_oe[i])
      else $error("push pull output not driven");

    // The driver needs output direction and plain mode both
    a_oe_needs_gp: assert property (@(posedge sys_clk) disable iff (!nrst)
      pin_oe[i] |-> gp_drive[i])
      else $error("driver on outside plain output");
  end
endmodule // pmc_port2

/* tb/pmc_pins.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Board side of the eight port pins
// ----------------------------------------
module pmc_pins (
  // From the port
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // Level the board puts on a released pin
  input wire logic [7:0] ext_level,
  // Resolved wire level back to the port
  output logic [7:0] pin_in
);
  // A driven pin wins; a released pin shows the board level, never the old drive
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pmc_pins

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import pmc_pkg::*;
  logic sys_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, ext_level = 8'h00, reg_rdata, pin_in, pin_out, pin_oe;
  logic [5:0] mb;
  logic ud_in, int4_in, trig_in;
  int num_errors = 0, compares = 0;
  // ----------------------------------------
  // Port, pins and clock
  // ----------------------------------------
  pmc_port2 u_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .up_down_input(ud_in),
    .ext_interrupt4_input(int4_in), .converter_external_trigger(trig_in),
    .ext_interrupt0_pin_select(mb[3]), .up_down_control_select(mb[1]),
    .ext_interrupt4_pin_select(mb[0]), .capture_noise_filter_enable(mb[4]),
    .serial_out1_drain_mode(mb[2]), .serial_out2_drain_mode(mb[5]));
  pmc_pins u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Bus cycles and compares
  // ----------------------------------------
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Strobe dropped, then one idle edge so no signal is set twice in a step
  task automatic wr(logic [15:0] a, logic [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge sys_clk) reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(string nm, logic [15:0] a, logic [7:0] e);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
    @(posedge sys_clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd("mode", PMC_ADDR_MODE, PMC_RST_MODE);
    rd("drain", PMC_ADDR_DRAIN, 8'h00);
    rd("data", PMC_ADDR_DATA, 8'h00);
    rd("dir", PMC_ADDR_DIR, 8'hFF);
    rd("unmapped", 16'hFF00, 8'h00);
    chk("oe", 8'h00, pin_oe);
  endtask
  // Mixed directions: outputs read the latch, inputs read the pin
  task automatic t_readback;
    ext_level <= 8'hA3;
    wr(PMC_ADDR_DATA, 8'h55);
    wr(PMC_ADDR_DIR, 8'hF0);
    rd("dir wo", PMC_ADDR_DIR, 8'hFF);
    repeat (3) @(posedge sys_clk);
    rd("data", PMC_ADDR_DATA, 8'h53);
    chk("oe", 8'hF0, pin_oe);
    chk("out", 8'h55, pin_out);
  endtask
  task automatic t_mode;
    wr(PMC_ADDR_DIR, 8'hFF);
    wr(PMC_ADDR_MODE, 8'h3F);
    rd("mode", PMC_ADDR_MODE, 8'hFF);
    chk("mode bits", 8'h3F, {2'h0, mb});
    chk("oe alt", 8'hFC, pin_oe);
    wr(PMC_ADDR_MODE, 8'h00);
    chk("mode off", 8'h00, {2'h0, mb});
    rd("mode fixed", PMC_ADDR_MODE, PMC_RST_MODE);
    chk("oe gpio", 8'hFF, pin_oe);
  endtask
  // Open drain releases the pins whose latch bit is one
  task automatic t_drain;
    wr(PMC_ADDR_DATA, 8'h0F);
    wr(PMC_ADDR_DRAIN, 8'hFF);
    rd("drain", PMC_ADDR_DRAIN, 8'hFF);
    chk("oe drain", 8'hF0, pin_oe);
  endtask
  // Alternate inputs on pins 0 and 1; software keeps interrupt 4 disabled outside
  task automatic t_alt;
    ext_level <= 8'h00;
    repeat (3) @(posedge sys_clk);
    chk("alt idle", 8'h07, {5'h00, ud_in, int4_in, trig_in});
    wr(PMC_ADDR_MODE, 8'h03);
    repeat (3) @(posedge sys_clk);
    chk("alt low", 8'h00, {5'h00, ud_in, int4_in, trig_in});
    ext_level <= 8'h01;
    repeat (3) @(posedge sys_clk);
    chk("alt mixed", 8'h03, {5'h00, ud_in, int4_in, trig_in});
    wr(PMC_ADDR_MODE, 8'h00);
  endtask
  // Reset again in mid-run: registers and drivers go back to reset state
  task automatic t_rereset;
    wr(PMC_ADDR_DRAIN, 8'h5A);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    chk("oe rst", 8'h00, pin_oe);
    chk("out rst", 8'h00, pin_out);
    rd("mode rst", PMC_ADDR_MODE, PMC_RST_MODE);
    rd("drain rst", PMC_ADDR_DRAIN, 8'h00);
  endtask
  task automatic give_verdict;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_readback();
    t_mode();
    t_drain();
    t_alt();
    t_rereset();
    give_verdict();
  end
  // Whole run is about eighty cycles
  initial begin
    repeat (2000) @(posedge sys_clk);
    num_errors++;
    give_verdict();
  end
endmodule // tb_top
